// ===== rtl/dsfm_pkg.sv
/*
 * Constants for the drive status and fault monitor: parameter addresses,
 * field positions, reset values and timing counts.
 * Assumes a single 50 MHz core clock and 16-bit parameter words.
 */
package dsfm_pkg;

	// ----------------------------------------------------------------
	// Parameter addresses and widths
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W         = 16;
	localparam int unsigned DATA_W         = 16;
	localparam logic [15:0] OFF_MAINS_RESP = 16'h0514;
	localparam logic [15:0] OFF_TRK_RESP   = 16'h0516;
	localparam logic [15:0] OFF_ACTION     = 16'h1c08;
	localparam logic [15:0] OFF_STOP_FAULT = 16'h1c0a;
	localparam logic [15:0] OFF_WARN       = 16'h1c18;

	// ----------------------------------------------------------------
	// Reset values and legal range of the response settings
	// ----------------------------------------------------------------
	localparam logic [15:0] RST_MAINS_RESP = 16'h0002;
	localparam logic [15:0] RST_TRK_RESP   = 16'h0003;
	localparam logic [15:0] RESP_MIN       = 16'h0001;
	localparam logic [15:0] RESP_MAX       = 16'h0003;
	localparam logic [15:0] RST_WORD       = 16'h0000;

	// ----------------------------------------------------------------
	// Warning word fields
	// ----------------------------------------------------------------
	localparam int unsigned WB_GENERAL     = 0;
	localparam int unsigned WB_AMP_TEMP    = 1;
	localparam int unsigned WB_MOT_TEMP    = 2;
	localparam int unsigned WB_AMP_I2T     = 4;
	localparam int unsigned WB_MOT_I2T     = 5;
	localparam int unsigned WB_BRK_I2T     = 6;
	localparam int unsigned WB_CAN         = 7;
	localparam int unsigned WB_ENCODER     = 8;
	localparam int unsigned WB_RS485       = 9;
	localparam int unsigned WB_PWR_REMOVAL = 10;
	localparam int unsigned WB_DC_UNDERV   = 11;
	localparam int unsigned WB_FIELDBUS2   = 12;
	localparam int unsigned WB_POS_PENDING = 13;
	localparam logic [15:0] WARN_VALID     = 16'h3ff7;
	localparam logic [15:0] WARN_SELFCLR   = 16'h2c00;

	// ----------------------------------------------------------------
	// Action word fields
	// ----------------------------------------------------------------
	localparam int unsigned AB_CLASS0      = 0;
	localparam int unsigned AB_CLASS4      = 4;
	localparam int unsigned AB_STOPPED     = 6;
	localparam int unsigned AB_POS_DIR     = 7;
	localparam int unsigned AB_NEG_DIR     = 8;
	localparam int unsigned AB_POS_WIN     = 9;
	localparam int unsigned AB_PG_STOP     = 11;
	localparam int unsigned AB_PG_DEC      = 12;
	localparam int unsigned AB_PG_ACC      = 13;
	localparam int unsigned AB_PG_CONST    = 14;
	localparam int unsigned NUM_CLASSES    = 5;

	// ----------------------------------------------------------------
	// Motion and commutation monitor
	// ----------------------------------------------------------------
	localparam logic signed [15:0] STOP_SPEED_RPM = 16'sh0009;
	localparam logic [15:0] COMMUT_FAULT_CODE     = 16'h157f;
	localparam int unsigned CLK_HZ                = 50000000;
	localparam int unsigned COMMUT_WINDOW_MS      = 5;
	localparam int unsigned COMMUT_CYCLES         = COMMUT_WINDOW_MS * (CLK_HZ / 1000);
	localparam int unsigned COMMUT_CNT_W          = 20;

	// ----------------------------------------------------------------
	// Parameter access sequencer
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		BS_IDLE   = 2'b00,
		BS_SAMPLE = 2'b01,
		BS_RESP   = 2'b10
	} dsfm_bus_state_t;

endpackage

// ===== rtl/dsfm_snapshot.sv
/*
 * Snapshot store for the three status words.
 * Assumes the caller pulses load for one cycle to freeze a coherent copy.
 */
`timescale 1ns/10ps
module dsfm_snapshot (
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	input  wire logic        load,
	input  wire logic [47:0] snap_d,
	output logic      [47:0] snap_q
);

	// ----------------------------------------------------------------
	// Capture
	// ----------------------------------------------------------------
	logic [47:0] snap_nxt;

	always_comb begin
		snap_nxt = load ? snap_d : snap_q;
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			snap_q <= 48'h000000000000;
		end else begin
			snap_q <= snap_nxt;
		end
	end

endmodule

// ===== rtl/dsfm_top.sv
/*
 * Drive status and fault monitor: latched warning word, action word,
 * last stop fault number, two error response settings and the
 * commutation monitor, reached through a parameter access port.
 * Assumes inputs synchronous to core_clk and one request at a time.
 */
// Summary of operation
// R1: Latched warning bits stay set until a fault clear request.
// R2: Warning bits 10, 11 and 13 follow their condition and self-clear.
// R3: Bit 1 amplifier temperature high, bit 2 motor temperature high; one means active.
// R4: Bits 4 to 6 flag I2t overloads; bit 0 a general warning.
// R5: Bits 7, 8, 9, 12 flag CAN, encoder, RS485 and second fieldbus warnings.
// R6: Bit 10 power removal inputs, bit 11 undervoltage or mains phase, bit 13 position pending.
// R7: Warning bits 3, 14, 15 are reserved and read zero.
// R8: Action bits 0 to 4 show active error classes 0 to 4.
// R9: Action bit 6 set while speed magnitude below 9 rpm.
// R10: Action bit 7 positive rotation, bit 8 negative rotation.
// R11: Action bit 9 within position window; bits 5, 10, 15 reserved.
// R12: Action bits 11 to 14 show profile generator phase.
// R13: Read-only word holds fault number of the last stop cause.
// R14: Tracking error response takes 1 to 3, selects class, defaults to 3.
// R15: Mains phase response takes 1 to 3, selects class, defaults to 2.
// R16: Commutation monitor checks acceleration against torque for plausibility.
// R17: Acceleration against braking torque beyond the window signals uncontrolled movement.
// R18: Commutation fault is class 4 and shows flashing code 5503.
// R19: Master writes only 1 to 3; other values are refused unchanged.
// R20: All status words are read from one coherent snapshot.
`timescale 1ns/10ps
module dsfm_top #(
	parameter int unsigned COMMUT_CYCLES = dsfm_pkg::COMMUT_CYCLES
) (
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	input  wire logic [15:0] par_addr,
	input  wire logic        par_rd,
	input  wire logic        par_wr,
	input  wire logic [15:0] par_wdata,
	output logic      [15:0] par_rdata,
	output logic             par_ack,
	output logic             par_err,
	input  wire logic        fault_clear_request,
	input  wire logic [15:0] warn_cond,
	input  wire logic        power_removal_input_a,
	input  wire logic        power_removal_input_b,
	input  wire logic        dc_undervoltage,
	input  wire logic        mains_phase_fault,
	input  wire logic        tracking_error,
	input  wire logic [4:0]  err_class_in,
	input  wire logic signed [15:0] speed_act,
	input  wire logic        in_pos_window,
	input  wire logic        pg_stopped,
	input  wire logic        pg_decel,
	input  wire logic        pg_accel,
	input  wire logic        pg_const,
	input  wire logic        stop_event,
	input  wire logic [15:0] stop_fault_code,
	input  wire logic signed [15:0] motor_accel,
	input  wire logic signed [15:0] motor_torque,
	output logic [4:0]       error_class_active,
	output logic             commut_fault,
	output logic             hmi_flash,
	output logic [15:0]      warning_word_display_code
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	localparam logic [19:0] COMMUT_LIMIT = 20'(COMMUT_CYCLES - 1);

	logic [15:0]             warn_raw;
	logic [15:0]             warn_d;
	logic [15:0]             warn_q;
	logic [15:0]             mains_resp_d;
	logic [15:0]             mains_resp_q;
	logic [15:0]             trk_resp_d;
	logic [15:0]             trk_resp_q;
	logic                    wr_ok;
	logic                    wr_hit;
	logic                    mains_flt_d;
	logic                    mains_flt_q;
	logic                    trk_flt_d;
	logic                    trk_flt_q;
	logic [19:0]             cnt_d;
	logic [19:0]             cnt_q;
	logic                    implausible;
	logic                    commut_det;
	logic                    commut_d;
	logic                    commut_q;
	logic [4:0]              cls_d;
	logic [4:0]              cls_q;
	logic [15:0]             action_d;
	logic [15:0]             action_q;
	logic [15:0]             stop_d;
	logic [15:0]             stop_q;
	logic [15:0]             hmi_d;
	logic [15:0]             hmi_q;
	logic signed [15:0]      speed_mag;
	dsfm_pkg::dsfm_bus_state_t st_d;
	dsfm_pkg::dsfm_bus_state_t st_q;
	logic [15:0]             addr_d;
	logic [15:0]             addr_q;
	logic [15:0]             rdata_d;
	logic [15:0]             rdata_q;
	logic                    err_d;
	logic                    err_q;
	logic                    snap_load;
	logic [47:0]             snap_q;

	// ----------------------------------------------------------------
	// Latched warning word
	// ----------------------------------------------------------------
	always_comb begin
		warn_raw = warn_cond;
		warn_raw[dsfm_pkg::WB_PWR_REMOVAL] = ~power_removal_input_a | ~power_removal_input_b; // R6
		warn_raw[dsfm_pkg::WB_DC_UNDERV] = dc_undervoltage | mains_phase_fault; // R6
	end

	for (genvar i = 0; i < 16; i++) begin : g_warn
		if (!dsfm_pkg::WARN_VALID[i]) begin : g_rsvd
			assign warn_d[i] = 1'b0; // R7
		end else if (dsfm_pkg::WARN_SELFCLR[i]) begin : g_self
			assign warn_d[i] = warn_raw[i]; // R2
		end else begin : g_latch
			assign warn_d[i] = warn_raw[i] | (warn_q[i] & ~fault_clear_request); // R1 R3 R4 R5
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			warn_q <= dsfm_pkg::RST_WORD;
		end else begin
			warn_q <= warn_d;
		end
	end

	// ----------------------------------------------------------------
	// Error response settings
	// ----------------------------------------------------------------
	always_comb begin
		wr_ok = (par_wdata >= dsfm_pkg::RESP_MIN) && (par_wdata <= dsfm_pkg::RESP_MAX); // R19
		wr_hit = (st_q == dsfm_pkg::BS_IDLE) && par_wr && !par_rd && wr_ok;
		mains_resp_d = mains_resp_q;
		trk_resp_d = trk_resp_q;
		if (wr_hit && par_addr == dsfm_pkg::OFF_MAINS_RESP) begin
			mains_resp_d = par_wdata; // R15
		end
		if (wr_hit && par_addr == dsfm_pkg::OFF_TRK_RESP) begin
			trk_resp_d = par_wdata; // R14
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			mains_resp_q <= dsfm_pkg::RST_MAINS_RESP; // R15
			trk_resp_q <= dsfm_pkg::RST_TRK_RESP; // R14
		end else begin
			mains_resp_q <= mains_resp_d;
			trk_resp_q <= trk_resp_d;
		end
	end

	// ----------------------------------------------------------------
	// Commutation monitor
	// ----------------------------------------------------------------
	always_comb begin
		implausible = ((motor_accel > 16'sh0000) && (motor_torque < 16'sh0000))
			|| ((motor_accel < 16'sh0000) && (motor_torque > 16'sh0000)); // R16
		commut_det = implausible && (cnt_q == COMMUT_LIMIT); // R17
		cnt_d = 20'h00000;
		if (implausible && cnt_q != COMMUT_LIMIT) begin
			cnt_d = cnt_q + 20'h00001;
		end else if (implausible) begin
			cnt_d = cnt_q;
		end
		commut_d = commut_det | (commut_q & ~fault_clear_request); // R18
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= 20'h00000;
			commut_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			commut_q <= commut_d;
		end
	end

	// ----------------------------------------------------------------
	// Error classes and stop fault number
	// ----------------------------------------------------------------
	always_comb begin
		trk_flt_d = tracking_error | (trk_flt_q & ~fault_clear_request);
		mains_flt_d = mains_phase_fault | (mains_flt_q & ~fault_clear_request);
		cls_d = err_class_in;
		for (int k = 1; k < 4; k++) begin
			if (trk_flt_q && trk_resp_q == 16'(k)) begin
				cls_d[k] = 1'b1; // R14
			end
			if (mains_flt_q && mains_resp_q == 16'(k)) begin
				cls_d[k] = 1'b1; // R15
			end
		end
		cls_d[dsfm_pkg::AB_CLASS4] = err_class_in[dsfm_pkg::AB_CLASS4] | commut_q; // R18
		stop_d = stop_q;
		if (commut_det) begin
			stop_d = dsfm_pkg::COMMUT_FAULT_CODE; // R13 R18
		end else if (stop_event) begin
			stop_d = stop_fault_code; // R13
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			trk_flt_q <= 1'b0;
			mains_flt_q <= 1'b0;
			cls_q <= 5'h00;
			stop_q <= dsfm_pkg::RST_WORD;
		end else begin
			trk_flt_q <= trk_flt_d;
			mains_flt_q <= mains_flt_d;
			cls_q <= cls_d;
			stop_q <= stop_d;
		end
	end

	// ----------------------------------------------------------------
	// Operator display code
	// ----------------------------------------------------------------
	always_comb begin
		hmi_d = commut_d ? dsfm_pkg::COMMUT_FAULT_CODE : dsfm_pkg::RST_WORD; // R18
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			hmi_q <= dsfm_pkg::RST_WORD;
		end else begin
			hmi_q <= hmi_d;
		end
	end

	// ----------------------------------------------------------------
	// Action word
	// ----------------------------------------------------------------
	always_comb begin
		speed_mag = (speed_act < 16'sh0000) ? -speed_act : speed_act;
		action_d = dsfm_pkg::RST_WORD; // R11
		action_d[dsfm_pkg::AB_CLASS4:dsfm_pkg::AB_CLASS0] = cls_q; // R8
		action_d[dsfm_pkg::AB_STOPPED] = (speed_act == -16'sh8000)
			? 1'b0 : (speed_mag < dsfm_pkg::STOP_SPEED_RPM); // R9
		action_d[dsfm_pkg::AB_POS_DIR] = speed_act > 16'sh0000; // R10
		action_d[dsfm_pkg::AB_NEG_DIR] = speed_act < 16'sh0000; // R10
		action_d[dsfm_pkg::AB_POS_WIN] = in_pos_window; // R11
		action_d[dsfm_pkg::AB_PG_STOP] = pg_stopped; // R12
		action_d[dsfm_pkg::AB_PG_DEC] = pg_decel; // R12
		action_d[dsfm_pkg::AB_PG_ACC] = pg_accel; // R12
		action_d[dsfm_pkg::AB_PG_CONST] = pg_const; // R12
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			action_q <= dsfm_pkg::RST_WORD;
		end else begin
			action_q <= action_d;
		end
	end

	// ----------------------------------------------------------------
	// Snapshot of the status words
	// ----------------------------------------------------------------
	assign snap_load = (st_q == dsfm_pkg::BS_IDLE) && par_rd; // R20

	dsfm_snapshot u_snap (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.load     (snap_load),
		.snap_d   ({warn_q, action_q, stop_q}),
		.snap_q   (snap_q)
	);

	// ----------------------------------------------------------------
	// Parameter access sequencer
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		addr_d = addr_q;
		rdata_d = rdata_q;
		err_d = err_q;
		case (st_q)
			dsfm_pkg::BS_IDLE: begin
				if (par_rd) begin
					addr_d = par_addr;
					st_d = dsfm_pkg::BS_SAMPLE;
				end else if (par_wr) begin
					err_d = !(wr_ok && (par_addr == dsfm_pkg::OFF_MAINS_RESP
						|| par_addr == dsfm_pkg::OFF_TRK_RESP)); // R19
					st_d = dsfm_pkg::BS_RESP;
				end
			end
			dsfm_pkg::BS_SAMPLE: begin
				err_d = 1'b0;
				case (addr_q)
					dsfm_pkg::OFF_WARN: rdata_d = snap_q[47:32]; // R20
					dsfm_pkg::OFF_ACTION: rdata_d = snap_q[31:16]; // R20
					dsfm_pkg::OFF_STOP_FAULT: rdata_d = snap_q[15:0]; // R13
					dsfm_pkg::OFF_MAINS_RESP: rdata_d = mains_resp_q;
					dsfm_pkg::OFF_TRK_RESP: rdata_d = trk_resp_q;
					default: begin
						rdata_d = dsfm_pkg::RST_WORD;
						err_d = 1'b1;
					end
				endcase
				st_d = dsfm_pkg::BS_RESP;
			end
			dsfm_pkg::BS_RESP: begin
				st_d = dsfm_pkg::BS_IDLE;
			end
			default: begin
				st_d = dsfm_pkg::BS_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= dsfm_pkg::BS_IDLE;
			addr_q <= 16'h0000;
			rdata_q <= dsfm_pkg::RST_WORD;
			err_q <= 1'b0;
		end else begin
			st_q <= st_d;
			addr_q <= addr_d;
			rdata_q <= rdata_d;
			err_q <= err_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign par_rdata = rdata_q;
	assign par_ack = (st_q == dsfm_pkg::BS_RESP);
	assign par_err = err_q;
	assign error_class_active = cls_q; // R8
	assign commut_fault = commut_q; // R18
	assign hmi_flash = commut_q;
	assign warning_word_display_code = hmi_q;

endmodule

// ===== verif/dsfm_checker.sv
/*
 * Port assertions for dsfm_top, attached by bind.
 * Assumes one parameter request at a time, held until par_ack.
 */
`timescale 1ns/10ps
module dsfm_checker #(
	parameter int unsigned COMMUT_CYCLES = 8
) (
	input wire logic               core_clk,
	input wire logic               arst_n,
	input wire logic        [15:0] par_addr,
	input wire logic               par_rd,
	input wire logic               par_wr,
	input wire logic        [15:0] par_wdata,
	input wire logic        [15:0] par_rdata,
	input wire logic               par_ack,
	input wire logic               par_err,
	input wire logic               fault_clear_request,
	input wire logic        [4:0]  err_class_in,
	input wire logic signed [15:0] motor_accel,
	input wire logic signed [15:0] motor_torque,
	input wire logic        [4:0]  error_class_active,
	input wire logic               commut_fault,
	input wire logic               hmi_flash,
	input wire logic        [15:0] warning_word_display_code
);
	// --------------------
	// Helper logic
	// --------------------
	logic [31:0] run_q;
	logic [31:0] run_d;
	logic        odd;
	logic        wr_ok;
	logic        mapped;
	assign odd = (motor_accel > 0 && motor_torque < 0) || (motor_accel < 0 && motor_torque > 0);
	assign wr_ok = (par_addr == 16'h0514 || par_addr == 16'h0516)
		&& par_wdata >= 16'h0001 && par_wdata <= 16'h0003;
	assign mapped = par_addr inside {16'h0514, 16'h0516, 16'h1c08, 16'h1c0a, 16'h1c18};
	always_comb begin
		run_d = odd ? run_q + 32'h1 : 32'h0;
	end
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			run_q <= 32'h0;
		end else begin
			run_q <= run_d;
		end
	end
	// --------------------
	// Assertions
	// --------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	sequence s_wr_ans;
		par_ack;
	endsequence
	sequence s_rd_ans;
		!par_ack ##1 par_ack;
	endsequence
	property p_ack_pulse;
		par_ack |=> !par_ack;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	property p_wr_answer;
		$rose(par_wr) && !par_rd |=> s_wr_ans ##0 (par_err == !$past(wr_ok));
	endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("write answer wrong");
	property p_rd_answer;
		$rose(par_rd) |=> s_rd_ans;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
	property p_unmapped;
		$rose(par_rd) && !mapped |-> ##2 (par_ack && par_err && par_rdata == 16'h0000);
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read wrong");
	property p_hmi_on;
		commut_fault |-> hmi_flash && warning_word_display_code == 16'h157f;
	endproperty
	a_hmi_on: assert property (p_hmi_on) else $error("display code missing");
	property p_hmi_off;
		!commut_fault |-> !hmi_flash && warning_word_display_code == 16'h0000;
	endproperty
	a_hmi_off: assert property (p_hmi_off) else $error("display code stray");
	property p_commut_hold;
		commut_fault && !fault_clear_request |=> commut_fault;
	endproperty
	a_commut_hold: assert property (p_commut_hold) else $error("fault dropped");
	property p_commut_rise;
		$rose(commut_fault) |-> run_q >= COMMUT_CYCLES - 1;
	endproperty
	a_commut_rise: assert property (p_commut_rise) else $error("fault too early");
	property p_commut_late;
		run_q >= COMMUT_CYCLES + 2 |-> commut_fault;
	endproperty
	a_commut_late: assert property (p_commut_late) else $error("fault too late");
	property p_class_in;
		(error_class_active & $past(err_class_in)) == $past(err_class_in);
	endproperty
	a_class_in: assert property (p_class_in) else $error("class bit missing");
	property p_class4;
		commut_fault [*2] |-> error_class_active[4];
	endproperty
	a_class4: assert property (p_class4) else $error("class 4 missing");
endmodule

bind dsfm_top dsfm_checker #(.COMMUT_CYCLES(COMMUT_CYCLES)) i_chk (
	.core_clk, .arst_n, .par_addr, .par_rd, .par_wr, .par_wdata, .par_rdata,
	.par_ack, .par_err, .fault_clear_request, .err_class_in, .motor_accel,
	.motor_torque, .error_class_active, .commut_fault, .hmi_flash,
	.warning_word_display_code
);

// ===== verif/dsfm_master_model.sv
/*
 * Fieldbus master model for the parameter port of dsfm_top.
 * Assumes the caller runs one transfer at a time.
 */
`timescale 1ns/10ps
module dsfm_master_model (
	input  wire logic        core_clk,
	input  wire logic [15:0] par_rdata,
	input  wire logic        par_ack,
	input  wire logic        par_err,
	output logic      [15:0] par_addr,
	output logic             par_rd,
	output logic             par_wr,
	output logic      [15:0] par_wdata
);
	initial begin
		par_addr = 16'h0000;
		par_rd = 1'b0;
		par_wr = 1'b0;
		par_wdata = 16'h0000;
	end
	// Request held until the edge that samples par_ack; released lines show inverted
	task automatic xfer(input logic wr, input logic [15:0] addr, input logic [15:0] wdata,
		output logic [15:0] rdata, output logic err, output logic done);
		int n;
		done = 1'b0;
		@(posedge core_clk);
		par_addr <= addr;
		par_wdata <= wdata;
		par_rd <= !wr;
		par_wr <= wr;
		for (n = 0; n < 16 && !done; n++) begin
			@(posedge core_clk);
			done = (par_ack === 1'b1);
		end
		rdata = par_rdata;
		err = par_err;
		par_rd <= 1'b0;
		par_wr <= 1'b0;
		par_addr <= ~addr;
		par_wdata <= ~wdata;
	endtask
endmodule

// ===== verif/tb_top.sv
/*
 * Self-checking testbench for dsfm_top.
 * Assumes a 50 MHz clock and a shortened commutation window.
 */
`timescale 1ns/10ps
module tb_top;
	localparam int unsigned CC = 8;
	localparam logic [15:0] ACT [5] = '{16'h0881, 16'h1282, 16'h20c4, 16'h4348, 16'h0910};
	localparam logic signed [15:0] SPD [5] = '{16'sh0064, 16'sh0009, 16'sh0008,
		16'shfff8, 16'shfff7};
	logic core_clk, arst_n, par_rd, par_wr, par_ack, par_err;
	logic [15:0] par_addr, par_wdata, par_rdata, warn_cond, stop_fault_code;
	logic fault_clear_request, power_removal_input_a, power_removal_input_b;
	logic dc_undervoltage, mains_phase_fault, tracking_error, in_pos_window, stop_event;
	logic pg_stopped, pg_decel, pg_accel, pg_const, commut_fault, hmi_flash;
	logic [4:0] err_class_in, error_class_active;
	logic signed [15:0] speed_act, motor_accel, motor_torque;
	logic [15:0] warning_word_display_code;
	int errors;
	int checks_done;

	dsfm_top #(.COMMUT_CYCLES(CC)) i_dut (
		.core_clk, .arst_n, .par_addr, .par_rd, .par_wr, .par_wdata, .par_rdata,
		.par_ack, .par_err, .fault_clear_request, .warn_cond, .power_removal_input_a,
		.power_removal_input_b, .dc_undervoltage, .mains_phase_fault, .tracking_error,
		.err_class_in, .speed_act, .in_pos_window, .pg_stopped, .pg_decel, .pg_accel,
		.pg_const, .stop_event, .stop_fault_code, .motor_accel, .motor_torque,
		.error_class_active, .commut_fault, .hmi_flash, .warning_word_display_code
	);
	dsfm_master_model i_mst (
		.core_clk, .par_rdata, .par_ack, .par_err, .par_addr, .par_rd, .par_wr, .par_wdata
	);

	always #10 core_clk = ~core_clk;

	// --------------------
	// Shared tasks
	// --------------------
	task automatic summarize;
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic ans(input logic ok);
		if (ok !== 1'b1) begin
			errors++;
			$display("BAD %0t no answer", $time);
			summarize();
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic rd(input logic [15:0] a, input logic [15:0] x, input logic e);
		logic [15:0] d;
		logic er;
		logic ok;
		i_mst.xfer(1'b0, a, 16'h0000, d, er, ok);
		ans(ok);
		chk(d, x);
		chk({15'h0, er}, {15'h0, e});
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] v, input logic e);
		logic [15:0] d;
		logic er;
		logic ok;
		i_mst.xfer(1'b1, a, v, d, er, ok);
		ans(ok);
		chk({15'h0, er}, {15'h0, e});
	endtask
	task automatic t_clear;
		@(posedge core_clk);
		fault_clear_request <= 1'b1;
		@(posedge core_clk);
		fault_clear_request <= 1'b0;
	endtask

	// --------------------
	// Scenarios
	// --------------------
	task automatic t_settings;
		rd(16'h0514, 16'h0002, 1'b0);
		rd(16'h0516, 16'h0003, 1'b0);
		rd(16'h1c18, 16'h0000, 1'b0);
		rd(16'h1c0a, 16'h0000, 1'b0);
		for (int v = 1; v <= 3; v++) begin
			wr(16'h0514, v[15:0], 1'b0);
			rd(16'h0514, v[15:0], 1'b0);
		end
		wr(16'h0516, 16'h0001, 1'b0);
		wr(16'h0516, 16'h0000, 1'b1);
		wr(16'h0516, 16'h0004, 1'b1);
		rd(16'h0516, 16'h0001, 1'b0);
		wr(16'h0514, 16'hffff, 1'b1);
		rd(16'h0514, 16'h0003, 1'b0);
		wr(16'h1c08, 16'h0001, 1'b1);
		rd(16'h0000, 16'h0000, 1'b1);
	endtask
	task automatic t_warn;
		warn_cond <= 16'hffff;
		power_removal_input_a <= 1'b0;
		dc_undervoltage <= 1'b1;
		cyc(3);
		rd(16'h1c18, 16'h3ff7, 1'b0);
		warn_cond <= 16'h0000;
		power_removal_input_a <= 1'b1;
		power_removal_input_b <= 1'b0;
		dc_undervoltage <= 1'b0;
		cyc(3);
		rd(16'h1c18, 16'h17f7, 1'b0);
		power_removal_input_b <= 1'b1;
		cyc(3);
		rd(16'h1c18, 16'h13f7, 1'b0);
		t_clear();
		cyc(3);
		rd(16'h1c18, 16'h0000, 1'b0);
	endtask
	task automatic t_action;
		for (int i = 0; i < 5; i++) begin
			speed_act <= SPD[i];
			err_class_in <= 5'h01 << i;
			in_pos_window <= i[0];
			{pg_const, pg_accel, pg_decel, pg_stopped} <= 4'h1 << (i % 4);
			cyc(4);
			chk({11'h0, error_class_active}, 16'h0001 << i);
			rd(16'h1c08, ACT[i], 1'b0);
		end
		err_class_in <= 5'h00;
	endtask
	task automatic t_class;
		tracking_error <= 1'b1;
		@(posedge core_clk);
		tracking_error <= 1'b0;
		cyc(4);
		chk({11'h0, error_class_active}, 16'h0002);
		mains_phase_fault <= 1'b1;
		@(posedge core_clk);
		mains_phase_fault <= 1'b0;
		cyc(4);
		chk({11'h0, error_class_active}, 16'h000a);
		t_clear();
		cyc(4);
		chk({11'h0, error_class_active}, 16'h0000);
	endtask
	task automatic t_commut;
		stop_fault_code <= 16'h00ab;
		stop_event <= 1'b1;
		@(posedge core_clk);
		stop_event <= 1'b0;
		cyc(2);
		rd(16'h1c0a, 16'h00ab, 1'b0);
		motor_accel <= 16'sh0064;
		motor_torque <= 16'shffce;
		cyc(CC - 3);
		motor_accel <= 16'sh0000;
		cyc(3);
		chk({15'h0, commut_fault}, 16'h0000);
		motor_accel <= 16'shff9c;
		motor_torque <= 16'sh0032;
		cyc(CC + 4);
		chk({15'h0, commut_fault}, 16'h0001);
		chk({15'h0, hmi_flash}, 16'h0001);
		chk(warning_word_display_code, 16'h157f);
		chk({11'h0, error_class_active}, 16'h0010);
		rd(16'h1c0a, 16'h157f, 1'b0);
		motor_accel <= 16'sh0000;
		t_clear();
		cyc(3);
		chk({15'h0, commut_fault}, 16'h0000);
	endtask

	initial begin
		core_clk = 1'b0;
		arst_n = 1'b0;
		{fault_clear_request, warn_cond, dc_undervoltage, mains_phase_fault, tracking_error,
			err_class_in, speed_act, in_pos_window, pg_stopped, pg_decel, pg_accel,
			pg_const, stop_event, stop_fault_code, motor_accel, motor_torque} = '0;
		{power_removal_input_a, power_removal_input_b} = 2'b11;
		errors = 0;
		checks_done = 0;
		cyc(6);
		arst_n <= 1'b1;
		t_settings();
		t_warn();
		t_action();
		t_class();
		t_commut();
		summarize();
	end
endmodule
